// >>> hdl/nac_consts.svh
`ifndef NAC_CONSTS_SVH
`define NAC_CONSTS_SVH
`define NAC_ID_DEPTH 8'h35
`define NAC_ID_GEOID 8'h36
`define NAC_ID_RTCM 8'h37
`define NAC_ID_WIND 8'h39
`define NAC_ID_HEAVE 8'h3A
`define NAC_ID_RAW 8'h3C
`define NAC_ID_EPH 8'h3D
`define NAC_LEN_DEPTH 16'h0008
`define NAC_LEN_GEOID 16'h0004
`define NAC_LEN_WIND 16'h000C
`define NAC_LEN_HEAVE 16'h0010
`define NAC_LEN_HDR 5'h10
`define NAC_LEN_SAT 5'h06
`define NAC_LEN_FRQ 5'h1A
`define NAC_SYS_MAX 8'h06
`define NAC_FRQ_MAX 8'h0A
`define NAC_TRK_RSV 8'hC0
`define NAC_SH_W 208
// Bit position of byte o of an n-byte record held at the top of the shifter
`define NAC_FLD(n, o) (`NAC_SH_W - 8 * (n) + 8 * (o))
`endif

// >>> hdl/nac_pkg.sv
`default_nettype none
package nac_pkg;
    typedef enum logic [1:0] {NAC_CMD_DEPTH, NAC_CMD_WIND, NAC_CMD_RTCM} nac_kind_t;
    typedef struct packed {
        nac_kind_t kind;
        logic [7:0] len;
        logic [31:0] w2;
        logic [31:0] w1;
        logic [31:0] w0;
    } nac_cmd_t;
    // Records arrive little-endian, so the field at offset 0 sits in the lowest bits
    typedef struct packed {
        logic [7:0] nsat;
        logic [7:0] total;
        logic [7:0] seq;
        logic [7:0] rcv;
        logic [31:0] clk_ofs;
        logic [31:0] nsec;
        logic [31:0] unix_s;
    } nac_hdr_t;
    typedef struct packed {
        logic [7:0] nfrq;
        logic [15:0] azim;
        logic [7:0] elev;
        logic [7:0] num;
        logic [7:0] sys;
    } nac_sat_t;
    typedef struct packed {
        logic [31:0] snr;
        logic [31:0] doppler;
        logic [63:0] range;
        logic [63:0] phase;
        logic [7:0] status;
        logic [7:0] code;
    } nac_frq_t;
endpackage
`default_nettype wire

// >>> hdl/nac_host.sv
`include "nac_consts.svh"
`default_nettype none
// ****************************************
// Correction byte FIFO
// ****************************************
module nac_fifo #(parameter int W = 8, parameter int D = 16) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Fill side
    input wire logic i_valid,
    input wire logic [W-1:0] i_data,
    output logic o_ready,
    // Drain side
    output logic o_valid,
    output logic [W-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp, rp;
    logic [AW:0] cnt, next_cnt;
    wire push = i_valid & o_ready;
    wire pop = o_valid & i_ready;
    // Count and flags are registered so ready and valid come from flops
    assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
    assign o_data = mem[rp];
    always_ff @(posedge i_clk) begin
        if (push) mem[wp] <= i_data;
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            o_ready <= 1'b0;
            o_valid <= 1'b0;
        end else begin
            wp <= push ? AW'((wp + 1'b1) % D) : wp;
            rp <= pop ? AW'((rp + 1'b1) % D) : rp;
            cnt <= next_cnt;
            o_ready <= next_cnt != (AW+1)'(D);
            o_valid <= next_cnt != '0;
        end
    end
endmodule
// ****************************************
// Host packet codec
// ****************************************
module nac_host import nac_pkg::*; #(parameter int FIFO_D = 16, parameter int LEN_W = 16) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // User write orders
    input wire logic i_cmd_valid,
    input wire nac_cmd_t i_cmd,
    output logic o_cmd_ready,
    input wire logic i_rtcm_valid,
    input wire logic [7:0] i_rtcm_data,
    output logic o_rtcm_ready,
    input wire logic i_raw_enable,
    // User status
    output logic o_raw_on,
    output logic o_eph_on,
    output logic o_wind_fixed,
    // Payload link toward the device
    output logic o_tx_valid,
    output logic o_tx_sop,
    output logic o_tx_eop,
    output logic [7:0] o_tx_id,
    output logic [LEN_W-1:0] o_tx_len,
    output logic [7:0] o_tx_data,
    input wire logic i_tx_ready,
    // Payload link from the device
    input wire logic i_rx_valid,
    input wire logic i_rx_sop,
    input wire logic [7:0] i_rx_id,
    input wire logic [LEN_W-1:0] i_rx_len,
    input wire logic [7:0] i_rx_data,
    output logic o_rx_ready,
    // Decoded results
    output logic o_depth_valid,
    output logic [63:0] o_depth,
    output logic o_geoid_valid,
    output logic [31:0] o_geoid,
    output logic o_wind_valid,
    output logic [95:0] o_wind,
    output logic o_heave_valid,
    output logic [127:0] o_heave,
    output logic o_hdr_valid,
    output nac_hdr_t o_hdr,
    output logic o_sat_valid,
    output nac_sat_t o_sat,
    output logic o_frq_valid,
    output nac_frq_t o_frq,
    output logic o_err_len,
    output logic o_err_code
);
    typedef enum {TX_IDLE, TX_FIX, TX_RTCM} nac_tx_t;
    typedef enum {RX_IDLE, RX_FIX, RX_SKIP, RX_HDR, RX_SAT, RX_FRQ} nac_rx_t;
    nac_tx_t tx_st;
    nac_rx_t rx_st, id_st, cur_st;
    logic [87:0] tx_sh;
    logic [7:0] tx_rem;
    logic [`NAC_SH_W-1:0] sh;
    logic [LEN_W-1:0] pos, len;
    logic [7:0] pid, sats, frqs;
    logic [4:0] sec;
    logic f_valid;
    logic [7:0] f_data;
    // ****************************************
    // Write side
    // ****************************************
    wire tx_hs = o_tx_valid & i_tx_ready;
    wire slot_free = ~o_tx_valid | tx_hs;
    wire cmd_go = i_cmd_valid & o_cmd_ready & (i_cmd.len != 8'h00 || i_cmd.kind != NAC_CMD_RTCM);
    wire f_pop = tx_st == TX_RTCM && tx_rem != 8'h00 && f_valid && slot_free;
    wire [7:0] fix_len = i_cmd.kind == NAC_CMD_WIND ? 8'(`NAC_LEN_WIND) : 8'(`NAC_LEN_DEPTH);
    nac_fifo #(.W(8), .D(FIFO_D)) u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_valid(i_rtcm_valid),
        .i_data(i_rtcm_data),
        .o_ready(o_rtcm_ready),
        .o_valid(f_valid),
        .o_data(f_data),
        .i_ready(f_pop)
    );
    // Serialiser; a correction packet stalls on an empty FIFO rather than padding
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_st <= TX_IDLE;
            {o_tx_valid, o_tx_sop, o_tx_eop, o_tx_id, o_tx_len, o_tx_data} <= '0;
            {tx_sh, tx_rem} <= '0;
            o_cmd_ready <= 1'b0;
            o_wind_fixed <= 1'b0;
        end else begin
            o_cmd_ready <= tx_st == TX_IDLE && !cmd_go;
            if (tx_hs) o_tx_sop <= 1'b0;
            // estimator off once a wind write is taken
            if (tx_hs && o_tx_sop && o_tx_id == `NAC_ID_WIND) o_wind_fixed <= 1'b1;
            unique case (tx_st)
                TX_IDLE: if (cmd_go) begin
                    o_tx_sop <= 1'b1;
                    if (i_cmd.kind == NAC_CMD_RTCM) begin
                        // length 1..255, bytes follow from the FIFO
                        tx_st <= TX_RTCM;
                        o_tx_id <= `NAC_ID_RTCM;
                        o_tx_len <= LEN_W'(i_cmd.len);
                        tx_rem <= i_cmd.len;
                    end else begin
                        tx_st <= TX_FIX;
                        o_tx_valid <= 1'b1;
                        o_tx_id <= i_cmd.kind == NAC_CMD_WIND ? `NAC_ID_WIND : `NAC_ID_DEPTH;
                        o_tx_len <= LEN_W'(fix_len);
                        o_tx_data <= i_cmd.w0[7:0];
                        tx_sh <= {i_cmd.w2, i_cmd.w1, i_cmd.w0[31:8]};
                        tx_rem <= fix_len - 8'h01;
                        o_tx_eop <= 1'b0;
                    end
                end
                TX_FIX: if (tx_hs) begin
                    if (tx_rem == 8'h00) begin
                        tx_st <= TX_IDLE;
                        o_tx_valid <= 1'b0;
                    end else begin
                        o_tx_data <= tx_sh[7:0];
                        tx_sh <= tx_sh >> 8;
                        tx_rem <= tx_rem - 8'h01;
                        o_tx_eop <= tx_rem == 8'h01;
                    end
                end
                TX_RTCM: begin
                    if (f_pop) begin
                        o_tx_valid <= 1'b1;
                        o_tx_data <= f_data;
                        tx_rem <= tx_rem - 8'h01;
                        o_tx_eop <= tx_rem == 8'h01;
                    end else if (tx_hs) begin
                        o_tx_valid <= 1'b0;
                    end
                    if (tx_rem == 8'h00 && slot_free) tx_st <= TX_IDLE;
                end
            endcase
        end
    end
    // ****************************************
    // Read side
    // ****************************************
    wire rx_hs = i_rx_valid & o_rx_ready;
    wire [`NAC_SH_W-1:0] sh_nx = {i_rx_data, sh[`NAC_SH_W-1:8]};
    wire [LEN_W-1:0] cur_pos = i_rx_sop ? '0 : pos;
    wire [LEN_W-1:0] cur_len = i_rx_sop ? i_rx_len : len;
    wire [7:0] cur_id = i_rx_sop ? i_rx_id : pid;
    wire [4:0] cur_sec = i_rx_sop ? 5'h00 : sec;
    wire last_byte = cur_pos + 1'b1 == cur_len;
    wire hdr_done = cur_st == RX_HDR && cur_sec == `NAC_LEN_HDR - 5'h01;
    wire sat_done = cur_st == RX_SAT && cur_sec == `NAC_LEN_SAT - 5'h01;
    wire frq_done = cur_st == RX_FRQ && cur_sec == `NAC_LEN_FRQ - 5'h01;
    // record structure must end on the last byte of the length
    wire raw_end = (hdr_done && i_rx_data == 8'h00) || (sat_done && i_rx_data == 8'h00 && sats == 8'h01)
        || (frq_done && frqs == 8'h01 && sats == 8'h01);
    wire is_raw = cur_st == RX_HDR || cur_st == RX_SAT || cur_st == RX_FRQ;
    wire [LEN_W-1:0] fix_want = cur_id == `NAC_ID_DEPTH ? `NAC_LEN_DEPTH : cur_id == `NAC_ID_GEOID ? `NAC_LEN_GEOID :
        cur_id == `NAC_ID_WIND ? `NAC_LEN_WIND : `NAC_LEN_HEAVE;
    assign id_st = (i_rx_id == `NAC_ID_DEPTH || i_rx_id == `NAC_ID_GEOID || i_rx_id == `NAC_ID_WIND
        || i_rx_id == `NAC_ID_HEAVE) ? RX_FIX : i_rx_id == `NAC_ID_RAW ? RX_HDR : RX_SKIP;
    assign cur_st = i_rx_sop ? id_st : rx_st;
    // Field shifter and position tracking
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            {sh, pos, len, pid} <= '0;
            o_rx_ready <= 1'b0;
        end else begin
            o_rx_ready <= 1'b1;
            if (rx_hs) {sh, pos, len, pid} <= {sh_nx, cur_pos + 1'b1, cur_len, cur_id};
        end
    end
    // Parser; a new start marker always restarts, so a cut packet cannot wedge it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_st <= RX_IDLE;
            {sec, sats, frqs} <= '0;
            {o_depth_valid, o_geoid_valid, o_wind_valid, o_heave_valid} <= '0;
            {o_hdr_valid, o_sat_valid, o_frq_valid, o_err_len, o_err_code} <= '0;
            {o_depth, o_geoid, o_wind, o_heave, o_hdr, o_sat, o_frq} <= '0;
            {o_raw_on, o_eph_on} <= '0;
        end else begin
            // ephemeris output follows the raw data enable
            o_raw_on <= i_raw_enable;
            o_eph_on <= i_raw_enable;
            {o_depth_valid, o_geoid_valid, o_wind_valid, o_heave_valid} <= '0;
            {o_hdr_valid, o_sat_valid, o_frq_valid, o_err_len, o_err_code} <= '0;
            if (rx_hs && cur_st == RX_FIX && last_byte) begin
                rx_st <= RX_IDLE;
                o_err_len <= cur_len != fix_want;
                o_depth_valid <= cur_id == `NAC_ID_DEPTH && cur_len == fix_want;
                o_depth <= sh_nx[`NAC_FLD(8, 0) +: 64];
                // separation kept exact for the downstream subtraction
                o_geoid_valid <= cur_id == `NAC_ID_GEOID && cur_len == fix_want;
                o_geoid <= sh_nx[`NAC_FLD(4, 0) +: 32];
                // wind as reported; trust it only with air data present
                o_wind_valid <= cur_id == `NAC_ID_WIND && cur_len == fix_want;
                o_wind <= sh_nx[`NAC_FLD(12, 0) +: 96];
                o_heave_valid <= cur_id == `NAC_ID_HEAVE && cur_len == fix_want;
                o_heave <= sh_nx[`NAC_FLD(16, 0) +: 128];
            end else if (rx_hs && is_raw && (raw_end || last_byte)) begin
                // short or long raw packet flagged
                rx_st <= RX_IDLE;
                o_err_len <= raw_end != last_byte;
            end else if (rx_hs && cur_st != RX_IDLE) begin
                rx_st <= cur_st;
                sec <= cur_sec + 5'h01;
            end else if (rx_hs && last_byte) begin
                rx_st <= RX_IDLE;
            end
            if (rx_hs && hdr_done) begin
                o_hdr_valid <= 1'b1;
                o_hdr <= sh_nx[`NAC_FLD(16, 0) +: 128];
                sats <= i_rx_data;
                sec <= 5'h00;
                if (!raw_end && !last_byte) rx_st <= RX_SAT;
            end
            // satellite record, reserved system codes flagged
            if (rx_hs && sat_done) begin
                o_sat_valid <= 1'b1;
                o_sat <= sh_nx[`NAC_FLD(6, 0) +: 48];
                o_err_code <= sh_nx[`NAC_FLD(6, 0) +: 8] > `NAC_SYS_MAX;
                frqs <= i_rx_data;
                sec <= 5'h00;
                if (i_rx_data == 8'h00) sats <= sats - 8'h01;
                if (!raw_end && !last_byte) rx_st <= i_rx_data == 8'h00 ? RX_SAT : RX_FRQ;
            end
            // frequency record with code and status checks
            if (rx_hs && frq_done) begin
                o_frq_valid <= 1'b1;
                o_frq <= sh_nx;
                o_err_code <= sh_nx[`NAC_FLD(26, 0) +: 8] > `NAC_FRQ_MAX
                    || (sh_nx[`NAC_FLD(26, 1) +: 8] & `NAC_TRK_RSV) != 8'h00;
                frqs <= frqs - 8'h01;
                sec <= 5'h00;
                if (frqs == 8'h01) sats <= sats - 8'h01;
                if (!raw_end && !last_byte) rx_st <= frqs == 8'h01 ? RX_SAT : RX_FRQ;
            end
        end
    end
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_depth_len: assert property (o_tx_valid && o_tx_id == `NAC_ID_DEPTH |-> o_tx_len == `NAC_LEN_DEPTH)
        else $error("depth write length wrong");
    a_rtcm_len: assert property (o_tx_sop && o_tx_id == `NAC_ID_RTCM |-> o_tx_len != '0)
        else $error("empty correction packet");
    a_wind_len: assert property (o_tx_valid && o_tx_id == `NAC_ID_WIND |-> o_tx_len == `NAC_LEN_WIND)
        else $error("wind write length wrong");
    a_wind_fix: assert property (tx_hs && o_tx_sop && o_tx_id == `NAC_ID_WIND |=> o_wind_fixed)
        else $error("wind write did not fix wind");
    a_eph_pair: assert property ($rose(o_raw_on) |-> o_eph_on ##1 o_eph_on || !o_raw_on)
        else $error("ephemeris not enabled with raw data");
    a_geoid_len: assert property (o_geoid_valid |-> $past(cur_len) == `NAC_LEN_GEOID)
        else $error("geoid published on wrong length");
    a_hdr_pos: assert property (o_hdr_valid |-> $past(cur_pos) == LEN_W'(`NAC_LEN_HDR - 5'h01))
        else $error("raw header at wrong byte");
    a_frq_size: assert property (o_frq_valid |-> $past(cur_sec) == `NAC_LEN_FRQ - 5'h01)
        else $error("frequency record not 26 bytes");
    a_trk_rsv: assert property (o_frq_valid && (o_frq.status & `NAC_TRK_RSV) != 8'h00 |-> o_err_code)
        else $error("reserved status bits not flagged");
    a_le_first: assert property (cmd_go && i_cmd.kind != NAC_CMD_RTCM |=> o_tx_data == $past(i_cmd.w0[7:0]))
        else $error("first byte not least significant");
endmodule
`default_nettype wire

// >>> test/nac_dev_model.sv
`default_nettype none
// ****************************************
// Device-side payload partner
// ****************************************
module nac_dev_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Write link from the controller
    input wire logic i_tx_valid,
    input wire logic i_tx_sop,
    input wire logic i_tx_eop,
    input wire logic [7:0] i_tx_id,
    input wire logic [15:0] i_tx_len,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_ready,
    // Read link toward the controller
    output logic o_rx_valid,
    output logic o_rx_sop,
    output logic [7:0] o_rx_id,
    output logic [15:0] o_rx_len,
    output logic [7:0] o_rx_data,
    input wire logic i_rx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] pkq[$];
    logic [33:0] txq[$];
    logic stall = 1'b0;
    logic wind_fixed = 1'b0;
    // Quiet link at time zero
    initial begin
        o_tx_ready = 1'b0;
        {o_rx_valid, o_rx_sop, o_rx_id, o_rx_len, o_rx_data} = '0;
    end
    // Sink stalls at random so the controller must hold each byte
    always @(posedge i_clk) begin
        // bytes kept in order, a wind write freezes the estimate
        if (o_tx_ready && i_tx_valid === 1'b1) begin
            txq.push_back({i_tx_sop, i_tx_eop, i_tx_id, i_tx_len, i_tx_data});
            if (i_tx_sop && i_tx_id == 8'h39) wind_fixed <= 1'b1;
        end
        #1 o_tx_ready <= !i_rst && !stall && $urandom_range(3) != 0;
    end
    // bytes leave in queue order, first one carries id and length
    task automatic send(input logic [7:0] id, input logic [15:0] len, input bit fin);
        int n;
        n = 0;
        while (pkq.size() > 0) begin
            if ($urandom_range(3) == 0) begin
                o_rx_valid <= 1'b0;
                o_rx_data <= ~o_rx_data;
                @(posedge i_clk);
                #1;
            end
            o_rx_valid <= 1'b1;
            o_rx_sop <= (n == 0);
            o_rx_id <= id;
            o_rx_len <= len;
            o_rx_data <= pkq.pop_front();
            n++;
            do @(posedge i_clk); while (i_rx_ready !== 1'b1);
            #1;
        end
        // Released data shows a changed value, never the last byte
        if (fin) begin
            o_rx_valid <= 1'b0;
            o_rx_sop <= 1'b0;
            o_rx_data <= ~o_rx_data;
        end
    endtask
endmodule
`default_nettype wire

// >>> test/tb_nac_host.sv
`default_nettype none
`define NAC_CHECK(g, e, m) begin n_compared++; if ((g) !== (e)) begin \
    failures++; $display("ERROR %0t %s", $time, m); end end
// ****************************************
// Codec bench
// ****************************************
module tb_nac_host import nac_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0, i_rst = 1'b1, i_cmd_valid = 1'b0, i_rtcm_valid = 1'b0, i_raw_enable = 1'b0;
    nac_cmd_t i_cmd = '0;
    logic [7:0] i_rtcm_data = 8'h00, i_rx_id, i_rx_data, o_tx_id, o_tx_data;
    logic [15:0] i_rx_len, o_tx_len;
    logic o_cmd_ready, o_rtcm_ready, o_raw_on, o_eph_on, o_wind_fixed, o_tx_valid, o_tx_sop, o_tx_eop;
    logic i_tx_ready, i_rx_valid, i_rx_sop, o_rx_ready, o_depth_valid, o_geoid_valid, o_wind_valid;
    logic o_heave_valid, o_hdr_valid, o_sat_valid, o_frq_valid, o_err_len, o_err_code;
    logic [63:0] o_depth;
    logic [31:0] o_geoid;
    logic [95:0] o_wind;
    logic [127:0] o_heave;
    nac_hdr_t o_hdr;
    nac_sat_t o_sat;
    nac_frq_t o_frq;
    logic [210:0] got[$], exp_q[$];
    logic [7:0] txb[$];
    int failures = 0, n_compared = 0, n_err_len = 0, n_err_code = 0;
    int rl[3] = '{1, 20, 255};
    int fl[4] = '{8, 4, 12, 16};
    logic [7:0] fid[4] = '{8'h35, 8'h36, 8'h39, 8'h3A};
    logic [7:0] bs[5] = '{8'h07, 8'h09, 8'h01, 8'h01, 8'h01};
    logic [7:0] bf[5] = '{8'h01, 8'h01, 8'h0B, 8'h01, 8'h01};
    logic [7:0] bt[5] = '{8'h01, 8'h01, 8'h01, 8'h40, 8'h80};
    nac_host #(.FIFO_D(16), .LEN_W(16)) dut (.i_clk, .i_rst, .i_cmd_valid, .i_cmd, .o_cmd_ready, .i_rtcm_valid,
        .i_rtcm_data, .o_rtcm_ready, .i_raw_enable, .o_raw_on, .o_eph_on, .o_wind_fixed, .o_tx_valid, .o_tx_sop,
        .o_tx_eop, .o_tx_id, .o_tx_len, .o_tx_data, .i_tx_ready, .i_rx_valid, .i_rx_sop, .i_rx_id, .i_rx_len,
        .i_rx_data, .o_rx_ready, .o_depth_valid, .o_depth, .o_geoid_valid, .o_geoid, .o_wind_valid, .o_wind,
        .o_heave_valid, .o_heave, .o_hdr_valid, .o_hdr, .o_sat_valid, .o_sat, .o_frq_valid, .o_frq, .o_err_len,
        .o_err_code);
    nac_dev_model dev (.i_clk, .i_rst, .i_tx_valid(o_tx_valid), .i_tx_sop(o_tx_sop), .i_tx_eop(o_tx_eop),
        .i_tx_id(o_tx_id), .i_tx_len(o_tx_len), .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready),
        .o_rx_valid(i_rx_valid), .o_rx_sop(i_rx_sop), .o_rx_id(i_rx_id), .o_rx_len(i_rx_len),
        .o_rx_data(i_rx_data), .i_rx_ready(o_rx_ready));
    // 10 MHz clock
    always #50 i_clk = ~i_clk;
    // Collect decoded records in arrival order, pulses are seen once each
    always @(posedge i_clk) begin
        if (o_hdr_valid === 1'b1) got.push_back({3'h0, 208'(o_hdr)});
        if (o_sat_valid === 1'b1) got.push_back({3'h1, 208'(o_sat)});
        if (o_frq_valid === 1'b1) got.push_back({3'h2, 208'(o_frq)});
        if (o_depth_valid === 1'b1) got.push_back({3'h3, 208'(o_depth)});
        if (o_geoid_valid === 1'b1) got.push_back({3'h4, 208'(o_geoid)});
        if (o_wind_valid === 1'b1) got.push_back({3'h5, 208'(o_wind)});
        if (o_heave_valid === 1'b1) got.push_back({3'h6, 208'(o_heave)});
        if (o_err_len === 1'b1) n_err_len++;
        if (o_err_code === 1'b1) n_err_code++;
    end
    // Watchdog: 20000 cycles is several times the expected run
    initial begin
        #(20000 * 100);
        failures++;
        conclude();
    end
    task automatic conclude();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic settle();
        repeat (4) @(posedge i_clk);
        #1;
    endtask
    // random record, byte i at bits 8i, with the control bytes placed
    task automatic rec(input logic [2:0] k, input int n, input logic [7:0] f0, f1, fl);
        logic [207:0] v;
        logic [7:0] b;
        v = '0;
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            if (i == 0 && (k == 3'h1 || k == 3'h2)) b = f0;
            if (i == 1 && k == 3'h2) b = f1;
            if (i == n - 1 && k < 3'h2) b = fl;
            if (i == 13 && k == 3'h0) b = 8'h01;
            if (i == 14 && k == 3'h0) b = f1;
            v[8*i +: 8] = b;
            dev.pkq.push_back(b);
        end
        exp_q.push_back({k, v});
    endtask
    task automatic match();
        settle();
        `NAC_CHECK(got.size(), exp_q.size(), "record count")
        while (got.size() > 0 && exp_q.size() > 0) `NAC_CHECK(got.pop_front(), exp_q.pop_front(), "record")
        got.delete();
        exp_q.delete();
    endtask
    task automatic order(input nac_kind_t k, input logic [7:0] n, input logic [95:0] w);
        int t;
        t = 0;
        i_cmd_valid = 1'b1;
        i_cmd = '{k, n, w[95:64], w[63:32], w[31:0]};
        do begin @(posedge i_clk); t++; end while (o_cmd_ready !== 1'b1 && t < 50);
        #1 i_cmd_valid = 1'b0;
        `NAC_CHECK(t < 50, 1'b1, "order not taken")
    endtask
    // Holds the byte until taken or the limit runs out; the caller lowers valid
    task automatic push(input logic [7:0] b, input int lim, output bit ok);
        int t;
        t = 0;
        i_rtcm_valid = 1'b1;
        i_rtcm_data = b;
        do begin @(posedge i_clk); t++; end while (o_rtcm_ready !== 1'b1 && t < lim);
        ok = (o_rtcm_ready === 1'b1);
        #1;
    endtask
    task automatic take_tx(input logic [7:0] id, input int n);
        logic [33:0] e;
        int t;
        t = 0;
        while (dev.txq.size() < n && t < 3000) begin @(posedge i_clk); t++; end
        #1;
        `NAC_CHECK(dev.txq.size(), n, "byte count")
        for (int i = 0; i < n && dev.txq.size() > 0; i++) begin
            e = dev.txq.pop_front();
            `NAC_CHECK(e, {i == 0, i == n - 1, id, 16'(n), txb.pop_front()}, "write byte")
        end
    endtask
    // Main sequence
    initial begin
        logic [95:0] w;
        logic [7:0] b;
        int e, cnt;
        bit ok;
        void'($urandom(32'h2013));
        repeat (4) @(posedge i_clk);
        #1;
        `NAC_CHECK({o_raw_on, o_eph_on, o_wind_fixed, o_tx_valid}, 4'h0, "reset state")
        i_rst = 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
        repeat (8) begin
            i_raw_enable = 1'($urandom);
            @(posedge i_clk);
            #1;
            `NAC_CHECK({o_raw_on, o_eph_on}, {2{i_raw_enable}}, "raw enable")
        end
        `NAC_CHECK(o_wind_fixed, 1'b0, "wind fixed early")
        for (int k = 0; k < 2; k++) begin
            w = k ? {$urandom, $urandom, $urandom} : {32'h0, 32'hFFFFFFFF, 32'h0};
            for (int i = 0; i < 8 + 4 * k; i++) txb.push_back(w[8*i +: 8]);
            order(k ? NAC_CMD_WIND : NAC_CMD_DEPTH, 8'h00, w);
            take_tx(k ? 8'h39 : 8'h35, 8 + 4 * k);
        end
        `NAC_CHECK(o_wind_fixed, 1'b1, "wind not fixed")
        `NAC_CHECK(dev.wind_fixed, 1'b1, "device still estimating wind")
        // Stalled sink on the second length fills the FIFO until it refuses
        foreach (rl[j]) begin
            dev.stall = (j == 1);
            order(NAC_CMD_RTCM, 8'(rl[j]), '0);
            cnt = 0;
            e = 0;
            for (int i = 0; i < rl[j]; i++) begin
                b = 8'($urandom);
                txb.push_back(b);
                push(b, 10, ok);
                if (!ok && j == 1 && e == 0) begin
                    `NAC_CHECK(cnt >= 16 && o_cmd_ready === 1'b0, 1'b1, "early refusal")
                    e = 1;
                    dev.stall = 1'b0;
                end
                if (!ok) push(b, 300, ok);
                cnt++;
            end
            i_rtcm_valid = 1'b0;
            if (j == 1) `NAC_CHECK(e, 1, "never refused")
            take_tx(8'h37, rl[j]);
        end
        // geoid and wind come back as plain numbers; air data validity is the user's to judge
        repeat (3) begin
            foreach (fl[k]) begin
                rec(3'(k + 3), fl[k], 0, 0, 0);
                dev.send(fid[k], 16'(fl[k]), k == 3);
            end
            match();
        end
        rec(0, 16, 0, 8'h02, 8'h07);
        for (int s = 0; s < 7; s++) begin
            rec(1, 6, 8'(s), 0, 8'h01);
            rec(2, 26, 8'($urandom_range(10)), 8'($urandom) & 8'h3F, 0);
        end
        dev.send(8'h3C, 16'h00F0, 1);
        match();
        rec(0, 16, 0, 8'h01, 8'h01);
        rec(1, 6, 8'h06, 0, 8'h02);
        rec(2, 26, 8'h0A, 8'h3F, 0);
        rec(2, 26, 8'h08, 8'h00, 0);
        dev.send(8'h3C, 16'h004A, 1);
        match();
        `NAC_CHECK(n_err_code + n_err_len, 0, "false error")
        foreach (bs[j]) begin
            e = n_err_code;
            rec(0, 16, 0, 8'h01, 8'h01);
            rec(1, 6, bs[j], 0, 8'h01);
            rec(2, 26, bf[j], bt[j], 0);
            dev.send(8'h3C, 16'h0030, 1);
            settle();
            `NAC_CHECK(n_err_code, e + 1, "bad code")
        end
        e = n_err_len;
        rec(0, 16, 0, 8'h01, 8'h01);
        rec(1, 6, 8'h01, 0, 8'h01);
        dev.send(8'h3C, 16'h0016, 1);
        settle();
        got.delete();
        rec(4, 5, 0, 0, 0);
        dev.send(8'h36, 16'h0005, 1);
        exp_q.delete();
        settle();
        `NAC_CHECK(n_err_len, e + 2, "length error")
        `NAC_CHECK(got.size(), 0, "result on bad length")
        conclude();
    end
endmodule
`default_nettype wire
